// ### design/asr_pkg.sv
// Package of constants and carriers for the static memory controller.
package asr_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int WORDS = 32768;

  // ****************************************************************
  // Timing in nanoseconds, slow grade, and clock rate
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDRESS_ACCESS_TIME_NS = 15;
  localparam int LANE_SELECT_ACCESS_TIME_NS = 7;
  localparam int WRITE_STROBE_WIDTH_NS = 10;
  localparam int WRITE_DATA_SETUP_NS = 8;
  localparam int ADDRESS_SETUP_TO_WRITE_END_NS = 10;
  localparam int DESELECT_TO_STANDBY_NS = 15;
  localparam int DESELECT_TO_FLOAT_NS = 7;
  localparam int SELECT_TO_DRIVE_NS = 3;

  // Least times round up to whole cycles, never below one.
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int READ_WAIT_CYC = cyc_up(ADDRESS_ACCESS_TIME_NS);
  localparam int WRITE_PULSE_CYC = cyc_up(WRITE_STROBE_WIDTH_NS);
  localparam int WR_SETUP_NS_MAX = (WRITE_DATA_SETUP_NS > ADDRESS_SETUP_TO_WRITE_END_NS) ?
      WRITE_DATA_SETUP_NS : ADDRESS_SETUP_TO_WRITE_END_NS;
  localparam int WRITE_HOLD_CYC = (cyc_up(WR_SETUP_NS_MAX) > WRITE_PULSE_CYC) ?
      cyc_up(WR_SETUP_NS_MAX) : WRITE_PULSE_CYC;
  localparam int TURN_CYC = cyc_up(DESELECT_TO_FLOAT_NS);
  localparam int CNT_W = 4;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic write;
    logic [1:0] lane_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_s;

  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_drive_n;
    logic high_lane_select_n;
    logic low_lane_select_n;
  } asr_ctl_s;

  localparam asr_ctl_s CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ### design/asr_cnt.sv
// Down counter that times the read, write pulse and turnaround phases of a memory access.
`timescale 1ns/10ps
module asr_cnt #(
  parameter int W = asr_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  assign cnt_next = load_i ? value_i : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
  // Done looks only at the register, since the load decision in the parent depends on it.
  assign done_o = (cnt_reg == '0);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ### design/asr_ctrl.sv
// Controller that drives the asynchronous 32K by 16 static memory through its pins.
// Contract
// RQ1: Memory holds 32768 sixteen-bit words, one word per fifteen-bit address.
// RQ2: Writes happen only while chip select and write strobe are both low.
// RQ3: Low lane select low during write stores data bits 1..8 as low byte.
// RQ4: High lane select low during write stores bits 9..16 as high byte.
// RQ5: Reads need chip select and output drive low, write strobe high throughout.
// RQ6: Low lane select low during read drives low byte onto bits 1..8.
// RQ7: High lane select low during read drives high byte onto bits 9..16.
// RQ8: Memory floats data pins when deselected, outputs disabled or both lanes off.
// RQ9: Memory never drives data while chip select and write strobe are low.
// RQ10: Chip select high puts memory in standby with both lanes floating.
// RQ11: Internal write lasts while select, strobe and a lane are all low.
// RQ12: Controller times data setup and hold to the edge ending the write.
// RQ13: Read data valid within 12 or 15 ns of stable address.
// RQ14: Old data stays valid at least 3 ns after address changes.
// RQ15: Lane data valid within 6 or 7 ns of lane select falling.
// RQ16: Controller holds write data at least 6 or 8 ns before write end.
// RQ17: Controller holds write strobe low at least 8 or 10 ns.
// RQ18: Controller sets address by write start and 8 or 10 ns before end.
// RQ19: Memory reaches standby within 12 or 15 ns of deselect.
// RQ20: Memory releases data pins faster than it starts driving them.
// RQ21: Unselected lane keeps contents during write and is not driven.
// RQ22: Contents survive standby and need no initialisation.
`timescale 1ns/10ps
module asr_ctrl (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire asr_pkg::asr_req_s req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [asr_pkg::DATA_W-1:0] rsp_data_o,
  output logic [asr_pkg::ADDR_W-1:0] mem_addr_o,
  output asr_pkg::asr_ctl_s mem_ctl_o,
  input wire logic [asr_pkg::DATA_W-1:0] mem_data_i,
  output logic [asr_pkg::DATA_W-1:0] mem_data_o,
  output logic [asr_pkg::DATA_W-1:0] mem_data_oe_o
);

  // ****************************************************************
  // States
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WSET = 5'h02,
    ST_WPULSE = 5'h04,
    ST_READ = 5'h08,
    ST_TURN = 5'h10
  } asr_state_e;

  // One extra cycle lets the read word pass both synchroniser flops before capture.
  localparam logic [asr_pkg::CNT_W-1:0] READ_LOAD = asr_pkg::CNT_W'(asr_pkg::READ_WAIT_CYC + 1);
  localparam logic [asr_pkg::CNT_W-1:0] WPULSE_LOAD =
      asr_pkg::CNT_W'(asr_pkg::WRITE_HOLD_CYC - 1);
  localparam logic [asr_pkg::CNT_W-1:0] TURN_LOAD = asr_pkg::CNT_W'(asr_pkg::TURN_CYC - 1);

  asr_state_e state_reg;
  asr_state_e state_next;
  asr_pkg::asr_req_s req_reg;
  asr_pkg::asr_ctl_s ctl_reg;
  asr_pkg::asr_ctl_s ctl_next;
  logic [1:0] oe_reg;
  logic [1:0] oe_next;
  logic [asr_pkg::DATA_W-1:0] rsp_data_reg;
  logic rsp_valid_reg;
  logic [asr_pkg::DATA_W-1:0] sync_a_reg;
  logic [asr_pkg::DATA_W-1:0] sync_b_reg;
  logic cnt_load;
  logic [asr_pkg::CNT_W-1:0] cnt_value;
  logic cnt_done;
  logic take;

  asr_cnt #(.W(asr_pkg::CNT_W)) u_cnt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(cnt_load),
    .value_i(cnt_value),
    .done_o(cnt_done)
  );

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  assign req_ready_o = (state_reg == ST_IDLE);
  assign take = req_valid_i && req_ready_o && (req_i.lane_en != 2'h0);
  assign cnt_load = (state_next != state_reg);
  assign cnt_value = (state_next == ST_READ) ? READ_LOAD :
      (state_next == ST_WPULSE) ? WPULSE_LOAD : TURN_LOAD;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = req_i.write ? ST_WSET : ST_READ;
        end
      end
      ST_WSET: state_next = ST_WPULSE;
      ST_WPULSE: begin
        if (cnt_done) begin
          state_next = ST_TURN;
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        if (cnt_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Address and lanes settle one cycle before the strobe falls, then the strobe
  // starts the write and rises with select and lanes to end it, so setup is timed to that rising edge. [RQ12] [RQ18]
  always_comb begin
    ctl_next = asr_pkg::CTL_IDLE;
    if (state_next == ST_WSET || state_next == ST_WPULSE || state_next == ST_READ) begin
      ctl_next.chip_select_n = 1'b0;
      ctl_next.low_lane_select_n = !(take ? req_i.lane_en[0] : req_reg.lane_en[0]);
      ctl_next.high_lane_select_n = !(take ? req_i.lane_en[1] : req_reg.lane_en[1]);
    end
    ctl_next.write_strobe_n = !(state_next == ST_WPULSE); // [RQ2] [RQ11] [RQ17]
    ctl_next.output_drive_n = !(state_next == ST_READ); // [RQ5]
  end

  // Write data drive only for enabled lanes and never during reads. [RQ3] [RQ4] [RQ21]
  assign oe_next = (state_next == ST_WSET || state_next == ST_WPULSE) ?
      (take ? req_i.lane_en : req_reg.lane_en) : 2'h0;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      ctl_reg <= asr_pkg::CTL_IDLE;
      oe_reg <= 2'h0;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      ctl_reg <= ctl_next;
      oe_reg <= oe_next; // [RQ16]
      if (take) begin
        req_reg <= req_i;
      end
    end
  end

  assign mem_ctl_o = ctl_reg;
  assign mem_addr_o = req_reg.addr; // [RQ1]
  assign mem_data_o = req_reg.wdata;
  assign mem_data_oe_o = {{asr_pkg::LANE_W{oe_reg[1]}}, {asr_pkg::LANE_W{oe_reg[0]}}};

  // ****************************************************************
  // Read capture
  // ****************************************************************
  // Memory data pins are outside this clock domain; two flops before use.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_a_reg <= '0;
      sync_b_reg <= '0;
    end else begin
      sync_a_reg <= mem_data_i;
      sync_b_reg <= sync_a_reg;
    end
  end

  // The access time is far below one clock, so after the wait the synchronised
  // word is stable; unselected lanes read as zero. [RQ6] [RQ7] [RQ13] [RQ15]
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_data_reg <= '0;
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= (state_reg == ST_READ) && cnt_done;
      if ((state_reg == ST_READ) && cnt_done) begin
        rsp_data_reg <= sync_b_reg & {{asr_pkg::LANE_W{req_reg.lane_en[1]}},
            {asr_pkg::LANE_W{req_reg.lane_en[0]}}};
      end
    end
  end

  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_data_o = rsp_data_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_no_drive_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ9]
      !mem_ctl_o.output_drive_n |-> (mem_data_oe_o == '0))
    else $error("controller drives data while memory output is enabled");
  a_write_strobe_only: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ2]
      !mem_ctl_o.write_strobe_n |-> !mem_ctl_o.chip_select_n && (mem_data_oe_o != '0))
    else $error("write strobe low without select or data");
  a_read_strobe_high: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ5]
      !mem_ctl_o.output_drive_n |-> mem_ctl_o.write_strobe_n && !mem_ctl_o.chip_select_n)
    else $error("read with write strobe low");
  a_addr_setup: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ18]
      $fell(mem_ctl_o.write_strobe_n) |-> $stable(mem_addr_o) && !mem_ctl_o.chip_select_n)
    else $error("address not settled at write start");
  a_data_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ16]
      $rose(mem_ctl_o.write_strobe_n) |-> $past(mem_data_oe_o) != '0 && $stable(mem_data_o))
    else $error("write data not held to write end");
  a_strobe_width: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ17]
      $fell(mem_ctl_o.write_strobe_n) |->
      !mem_ctl_o.write_strobe_n [*1] ##1 mem_ctl_o.write_strobe_n)
    else $error("write strobe pulse length wrong");
  a_lane_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ21]
      mem_ctl_o.low_lane_select_n |-> (mem_data_oe_o[asr_pkg::LANE_W-1:0] == '0))
    else $error("unselected low lane driven");
  a_read_answer: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ13]
      (take && !req_i.write) |-> ##[2:6] rsp_valid_o)
    else $error("read answer late");
  a_turnaround: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RQ20]
      $rose(mem_ctl_o.chip_select_n) |-> mem_data_oe_o == '0)
    else $error("data driven across deselect");

  c_write_full: cover property (@(posedge clk_i) take && req_i.write && req_i.lane_en == 2'h3);
  c_write_low: cover property (@(posedge clk_i) take && req_i.write && req_i.lane_en == 2'h1);
  c_read_high: cover property (@(posedge clk_i) take && !req_i.write && req_i.lane_en == 2'h2);
  c_read_done: cover property (@(posedge clk_i) rsp_valid_o);

endmodule

// ### dv/asr_mem_model.sv
// Behavioural model of the 32K by 16 static memory on the far side of the controller.
`timescale 1ns/10ps
module asr_mem_model (
  input wire logic [asr_pkg::ADDR_W-1:0] addr_i,
  input wire asr_pkg::asr_ctl_s ctl_i,
  input wire logic [asr_pkg::DATA_W-1:0] data_i,
  output logic [asr_pkg::DATA_W-1:0] data_o,
  output logic [asr_pkg::DATA_W-1:0] data_oe_o
);
  // Contents start unknown and survive deselect, so no set-up is needed.
  logic [asr_pkg::DATA_W-1:0] mem [asr_pkg::WORDS];
  logic [14:0] idx;
  logic sel, wr, rd, lo, hi;
  logic [asr_pkg::DATA_W-1:0] data_dly;
  // The controller releases data on the edge that ends the write; the short delay
  // keeps the old data in the cell until the strobe has risen, as zero hold allows.
  assign #1 data_dly = data_i;
  assign idx = addr_i[14:0];
  assign sel = ~ctl_i.chip_select_n;
  assign wr = sel & ~ctl_i.write_strobe_n;
  assign rd = sel & ~ctl_i.output_drive_n & ctl_i.write_strobe_n;
  assign lo = ~ctl_i.low_lane_select_n;
  assign hi = ~ctl_i.high_lane_select_n;
  // The write is level sensitive, so the last data seen before any control rises is kept.
  always @* begin
    if (wr & lo) mem[idx][7:0] = data_dly[7:0];
    if (wr & hi) mem[idx][15:8] = data_dly[15:8];
  end
  // Drive and release take no time, the fastest the timing allows.
  assign data_oe_o = {{8{rd & hi}}, {8{rd & lo}}};
  assign data_o = mem[idx];
endmodule

// ### dv/tb_top.sv
// Self-checking testbench of the static memory controller with a memory model.
`timescale 1ns/10ps
module tb_top;
  typedef logic [asr_pkg::DATA_W-1:0] asr_word_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  asr_pkg::asr_req_s req_i = '0;
  logic req_ready_o, rsp_valid_o;
  asr_word_t rsp_data_o, mem_addr_o, mem_data_o, mem_data_oe_o, mem_data_i, m_d, m_oe;
  asr_word_t float_v = 16'hA5A5;
  asr_pkg::asr_ctl_s mem_ctl_o;
  asr_word_t shadow [asr_pkg::WORDS];
  asr_word_t exp_q [$];
  logic [15:0] addr_l [40];
  logic [31:0] lfsr_v = 32'h00017C81;
  int err_total = 0;
  int num_checks = 0;

  // ****************************************************************
  // Clock, pins and instances
  // ****************************************************************
  initial forever #50 clk_i = ~clk_i;
  // An undriven bus toggles so that a stale value can never pass.
  always @(posedge clk_i) float_v <= ~float_v;
  assign mem_data_i = (mem_data_oe_o & mem_data_o) | (~mem_data_oe_o & m_oe & m_d) |
      (~mem_data_oe_o & ~m_oe & float_v);
  asr_ctrl u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .mem_addr_o(mem_addr_o), .mem_ctl_o(mem_ctl_o),
    .mem_data_i(mem_data_i), .mem_data_o(mem_data_o), .mem_data_oe_o(mem_data_oe_o));
  asr_mem_model u_mem (.addr_i(mem_addr_o), .ctl_i(mem_ctl_o), .data_i(mem_data_i),
    .data_o(m_d), .data_oe_o(m_oe));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input asr_word_t seen, input asr_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One request held until ready is seen; a read with a lane enabled notes its expected word.
  task automatic access(input logic wr, input logic [1:0] ln, input logic [15:0] a,
      input asr_word_t d);
    asr_word_t m;
    int n;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{wr, ln, a, d};
    do begin
      @(negedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 20);
    if (n == 20) check("req_ready_o", 16'h0000, 16'h0001);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    if (ln != 2'b00 && wr) shadow[a[14:0]] = (shadow[a[14:0]] & ~m) | (d & m);
    if (ln != 2'b00 && !wr) exp_q.push_back(shadow[a[14:0]] & m);
  endtask
  task automatic sweep(input logic wr, input int mode);
    logic [1:0] ln;
    for (int i = 0; i < 40; i++) begin
      lfsr_v = lfsr_next(lfsr_v);
      ln = (mode == 0) ? 2'b11 : (mode == 1) ? 2'(i % 3 + 1) : 2'b00;
      access(wr, ln, addr_l[i], lfsr_v[31:16]);
    end
    $display("test done: write %0b mode %0d", wr, mode);
  endtask

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(negedge clk_i) begin
    if (!sys_rst_i) begin
      if (rsp_valid_o === 1'b1 && exp_q.size() == 0) check("rsp_valid_o", 16'h0001, 16'h0000);
      else if (rsp_valid_o === 1'b1) check("rsp_data_o", rsp_data_o, exp_q.pop_front());
      if (mem_ctl_o.write_strobe_n === 1'b0) begin
        check("chip_select_n", 16'(mem_ctl_o.chip_select_n), 16'h0000);
        check("mem_data_oe_o", mem_data_oe_o, {{8{~mem_ctl_o.high_lane_select_n}},
          {8{~mem_ctl_o.low_lane_select_n}}});
      end
      if (mem_ctl_o.output_drive_n === 1'b0) check("write_strobe_n", 16'(mem_ctl_o.write_strobe_n), 16'h0001);
      check("bus overlap", mem_data_oe_o & m_oe, 16'h0000);
    end
  end

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    #(100 * 20000);
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 40; i++) begin
      lfsr_v = lfsr_next(lfsr_v);
      addr_l[i] = (i == 0) ? 16'h0000 : (i == 1) ? 16'h7FFF : {1'b0, lfsr_v[14:0]};
    end
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    sweep(1'b1, 0);
    sweep(1'b0, 0);
    sweep(1'b1, 1);
    sweep(1'b0, 1);
    sweep(1'b1, 2);
    sweep(1'b0, 2);
    for (int i = 0; i < 8; i++) begin
      lfsr_v = lfsr_next(lfsr_v);
      access(1'b1, 2'(i % 3 + 1), addr_l[i], lfsr_v[15:0]);
      access(1'b0, 2'b11, addr_l[i], 16'h0000);
    end
    // Let the last access finish so that reset cuts no pending read.
    repeat (10) @(posedge clk_i);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    sweep(1'b0, 0);
    repeat (10) @(posedge clk_i);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule
